// file: core/pin_mux_pkg.sv
// Package with constants and carrier types for the pin multiplexer.
package pin_mux_pkg;

   // Port indices within the port array.
   localparam int PORT_A = 0;
   localparam int PORT_B = 1;
   localparam int PORT_C = 2;
   localparam int PORT_D = 3;
   localparam int PORT_E = 4;
   localparam int PORT_F = 5;
   localparam int PORT_G = 6;
   localparam int PORT_H = 7;
   localparam int NUM_PORTS = 8;
   localparam int PORT_W = 8;

   // Sub-register indices: none, direction, alternate-function and open-drain bits.
   localparam logic [7:0] SUBREG_NONE = 8'h00;
   localparam logic [7:0] SUBREG_DIR = 8'h01;
   localparam logic [7:0] SUBREG_ALT = 8'h02;
   localparam logic [7:0] SUBREG_ODRAIN = 8'h03;

   // Reset values of the control bits.
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic [7:0] ALT_RESET = 8'h00;
   localparam logic [7:0] ODRAIN_RESET = 8'h00;
   localparam logic [7:0] INDEX_RESET = 8'h00;

   // Direction bit meaning.
   localparam logic DIR_OUT = 1'b0;
   localparam logic DIR_IN = 1'b1;

   // Package variants.
   typedef enum logic [1:0] {
      PKG_40,
      PKG_44,
      PKG_64,
      PKG_80
   } package_t;

   // Implemented pin masks per package, packed port H down to port A.
   localparam logic [63:0] MASK_40 = 64'h0000_0000_7B7F_FFFF;
   localparam logic [63:0] MASK_44 = 64'h0000_0000_7FFF_FFFF;
   localparam logic [63:0] MASK_64 = 64'h0F08_80FF_FFFF_FFFF;
   localparam logic [63:0] MASK_80 = 64'h0FFF_FFFF_FFFF_FFFF;

   // Pins that have an assigned alternate function, port H down to port A.
   localparam logic [63:0] ALT_EXISTS = 64'h0F00_0000_FBFF_FFFF;

   // Signals toward the on-chip peripherals.
   typedef struct packed {
      logic timer_zero_input;
      logic timer_one_input;
      logic timer_two_input;
      logic timer_three_input;
      logic serial0_clear_to_send;
      logic serial0_receive;
      logic serial1_clear_to_send;
      logic serial1_receive;
      logic spi_ss_in;
      logic spi_sck_in;
      logic spi_mosi_in;
      logic spi_miso_in;
      logic i2c_scl_in;
      logic i2c_sda_in;
      logic [11:0] analog_select;
   } periph_in_t;

   // Signals from the on-chip peripherals.
   typedef struct packed {
      logic timer_zero_output;
      logic timer_one_output;
      logic timer_two_output;
      logic timer_three_output;
      logic serial0_driver_enable;
      logic serial0_transmit;
      logic serial1_driver_enable;
      logic serial1_transmit;
      logic watchdog_osc_clock_out;
      logic spi_ss_out;
      logic spi_ss_oe;
      logic spi_sck_out;
      logic spi_sck_oe;
      logic spi_mosi_out;
      logic spi_mosi_oe;
      logic spi_miso_out;
      logic spi_miso_oe;
      logic i2c_scl_out;
      logic i2c_sda_out;
   } periph_out_t;

endpackage : pin_mux_pkg

// file: core/pin_edge_detect.sv
// Per-pin edge detector for the pin interrupt requests.
`timescale 1ns/100ps
`default_nettype none
module pin_edge_detect
   import pin_mux_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pin levels and edge configuration.
   input wire logic [WIDTH-1:0] level_i,
   input wire logic [WIDTH-1:0] has_select_i,
   input wire logic [WIDTH-1:0] rising_i,
   input wire logic [WIDTH-1:0] enable_i,
   // Requests.
   output logic [WIDTH-1:0] irq_o
);

   logic [WIDTH-1:0] last_q;
   logic [WIDTH-1:0] last_d;
   logic [WIDTH-1:0] irq_q;
   logic [WIDTH-1:0] irq_d;
   logic primed_q;
   logic primed_d;

   always_comb begin
      last_d = level_i;
      primed_d = 1'b1;
      for (int i = 0; i < WIDTH; i++) begin
         // Right after reset the stored level is not real, so a pin that
         // is already high would look like a rising edge.
         if (!enable_i[i] || !primed_q) begin
            irq_d[i] = 1'b0;
         end else if (has_select_i[i]) begin
            irq_d[i] = rising_i[i] ? (level_i[i] & ~last_q[i])
                                   : (~level_i[i] & last_q[i]); // [RQ10]
         end else begin
            irq_d[i] = level_i[i] ^ last_q[i]; // [RQ11]
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_q <= '0;
         primed_q <= 1'b0;
         irq_q <= '0;
      end else begin
         last_q <= last_d;
         primed_q <= primed_d;
         irq_q <= irq_d;
      end
   end

   assign irq_o = irq_q;

endmodule : pin_edge_detect
`default_nettype wire

// file: core/gpio_alt_function_mux.sv
// Per-pin alternate-function multiplexer for eight controller ports.
// How it works
// [RQ1] Per-pin select: clear is GPIO, set is peripheral.
// [RQ2] Selected pins take direction from their peripheral.
// [RQ3] Timers 0-2 on A1:0, C1:0, C7:6.
// [RQ4] Timer 3 on D1:0, absent on 44-pin.
// [RQ5] Serial 0 on A5:2.
// [RQ6] SPI on C5:2.
// [RQ7] Serial 1 on D6:3.
// [RQ8] D7 outputs watchdog oscillator clock.
// [RQ9] I2C on A7:6, forced open-drain.
// [RQ10] Selectable pins interrupt on chosen edge.
// [RQ11] Other pins interrupt on both edges.
// [RQ12] Implemented bits depend on package.
// [RQ13] Direction 0 drives output, 1 samples input.
// [RQ14] Select bits written via index 02H.
// [RQ15] Port B and H feed analog inputs.
// [RQ16] Pins without function stay plain GPIO.
`timescale 1ns/100ps
`default_nettype none
module gpio_alt_function_mux
   import pin_mux_pkg::*;
#(
   parameter package_t PKG = PKG_80
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control register port: index and window per port.
   input wire logic [2:0] port_sel_i,
   input wire logic port_subreg_index_we_i,
   input wire logic port_subreg_window_we_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] port_subreg_window_o,
   // Output data and edge configuration, port H down to port A.
   input wire logic [63:0] out_data_i,
   input wire logic [63:0] edge_select_avail_i,
   input wire logic [63:0] edge_rising_i,
   // Pins.
   input wire logic [63:0] pin_i,
   output logic [63:0] pin_o,
   output logic [63:0] pin_oe_o,
   // Port input data and interrupt requests.
   output logic [63:0] in_data_o,
   output logic [63:0] pin_irq_o,
   // Peripherals.
   input wire periph_out_t periph_i,
   output periph_in_t periph_o
);

   // Implemented pins of each package; unbonded bits stay quiet.
   function automatic logic [63:0] impl_mask(input package_t pkg);
      case (pkg)
         PKG_40: return MASK_40;
         PKG_44: return MASK_44;
         PKG_64: return MASK_64;
         default: return MASK_80;
      endcase
   endfunction : impl_mask

   localparam logic [63:0] IMPL = impl_mask(PKG);

   // Control state, one byte of each kind per port, and one readback byte for the window.
   logic [7:0] index_q [NUM_PORTS];
   logic [7:0] index_d [NUM_PORTS];
   logic [7:0] pin_direction_bits_q [NUM_PORTS];
   logic [7:0] pin_direction_bits_d [NUM_PORTS];
   logic [7:0] alt_function_select_bits_q [NUM_PORTS];
   logic [7:0] alt_function_select_bits_d [NUM_PORTS];
   logic [7:0] odrain_q [NUM_PORTS];
   logic [7:0] odrain_d [NUM_PORTS];
   logic [7:0] window_q;
   logic [7:0] window_d;

   logic [63:0] alt_on;
   logic [63:0] alt_val;
   logic [63:0] alt_oe;
   logic [63:0] out_d;
   logic [63:0] oe_d;
   logic [63:0] out_q;
   logic [63:0] oe_q;
   logic [63:0] in_d;
   logic [63:0] in_q;
   logic [63:0] irq_en;
   wire logic [63:0] irq_w;
   logic [63:0] irq_q;
   periph_in_t per_d;
   periph_in_t per_q;

   // Bit position of port p, pin b in the flat 64-bit vectors.
   function automatic int pos(input int p, input int b);
      return p * PORT_W + b;
   endfunction : pos

   // Control register writes through the sub-register window.
   // Readback is built from the next values, so a write shows at the same edge that stores it.
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         index_d[p] = index_q[p];
         pin_direction_bits_d[p] = pin_direction_bits_q[p];
         alt_function_select_bits_d[p] = alt_function_select_bits_q[p];
         odrain_d[p] = odrain_q[p];
         if (port_sel_i == 3'(p)) begin
            if (port_subreg_index_we_i) begin
               index_d[p] = wdata_i;
            end
            if (port_subreg_window_we_i) begin
               case (index_q[p])
                  SUBREG_DIR: pin_direction_bits_d[p] = wdata_i;
                  SUBREG_ALT: alt_function_select_bits_d[p] = wdata_i; // [RQ14]
                  SUBREG_ODRAIN: odrain_d[p] = wdata_i;
                  default: ;
               endcase
            end
         end
      end
      // Unused indices read as zero.
      case (index_d[port_sel_i])
         SUBREG_NONE: window_d = 8'h00;
         SUBREG_DIR: window_d = pin_direction_bits_d[port_sel_i];
         SUBREG_ALT: window_d = alt_function_select_bits_d[port_sel_i];
         SUBREG_ODRAIN: window_d = odrain_d[port_sel_i];
         default: window_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            index_q[p] <= INDEX_RESET;
            pin_direction_bits_q[p] <= DIR_RESET;
            alt_function_select_bits_q[p] <= ALT_RESET;
            odrain_q[p] <= ODRAIN_RESET;
         end
         window_q <= 8'h00;
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            index_q[p] <= index_d[p];
            pin_direction_bits_q[p] <= pin_direction_bits_d[p];
            alt_function_select_bits_q[p] <= alt_function_select_bits_d[p];
            odrain_q[p] <= odrain_d[p];
         end
         window_q <= window_d;
      end
   end

   // Pin drivers and peripheral routing.
   always_comb begin
      alt_val = '0;
      alt_oe = '0;
      per_d = '0;
      // A pin without an assigned function never leaves GPIO mode.
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int b = 0; b < PORT_W; b++) begin
            alt_on[pos(p, b)] = alt_function_select_bits_q[p][b]
                                & ALT_EXISTS[pos(p, b)]; // [RQ1] [RQ16]
         end
      end

      // The 44-pin parts leave timer 3 off port D.
      if (PKG == PKG_44) begin
         alt_on[pos(PORT_D, 0)] = 1'b0; // [RQ4]
         alt_on[pos(PORT_D, 1)] = 1'b0; // [RQ4]
      end
      alt_on = alt_on & IMPL;

      // Timers: inputs on even pins, outputs on odd pins.
      alt_oe[pos(PORT_A, 1)] = 1'b1; // [RQ3]
      alt_val[pos(PORT_A, 1)] = periph_i.timer_zero_output;
      alt_oe[pos(PORT_C, 1)] = 1'b1; // [RQ3]
      alt_val[pos(PORT_C, 1)] = periph_i.timer_one_output;
      alt_oe[pos(PORT_C, 7)] = 1'b1; // [RQ3]
      alt_val[pos(PORT_C, 7)] = periph_i.timer_two_output;
      alt_oe[pos(PORT_D, 1)] = 1'b1; // [RQ4]
      alt_val[pos(PORT_D, 1)] = periph_i.timer_three_output;
      per_d.timer_zero_input = alt_on[pos(PORT_A, 0)] & pin_i[pos(PORT_A, 0)];
      per_d.timer_one_input = alt_on[pos(PORT_C, 0)] & pin_i[pos(PORT_C, 0)];
      per_d.timer_two_input = alt_on[pos(PORT_C, 6)] & pin_i[pos(PORT_C, 6)];
      per_d.timer_three_input = alt_on[pos(PORT_D, 0)]
                                & pin_i[pos(PORT_D, 0)]; // [RQ4]

      // Serial channel 0.
      alt_oe[pos(PORT_A, 2)] = 1'b1; // [RQ5]
      alt_val[pos(PORT_A, 2)] = periph_i.serial0_driver_enable;
      alt_oe[pos(PORT_A, 5)] = 1'b1; // [RQ5]
      alt_val[pos(PORT_A, 5)] = periph_i.serial0_transmit;
      per_d.serial0_clear_to_send = ~alt_on[pos(PORT_A, 3)]
                                    | pin_i[pos(PORT_A, 3)]; // [RQ5]
      per_d.serial0_receive = ~alt_on[pos(PORT_A, 4)]
                              | pin_i[pos(PORT_A, 4)]; // [RQ5]

      // SPI: each pin's direction comes from the controller.
      alt_oe[pos(PORT_C, 2)] = periph_i.spi_ss_oe; // [RQ6]
      alt_val[pos(PORT_C, 2)] = periph_i.spi_ss_out;
      alt_oe[pos(PORT_C, 3)] = periph_i.spi_sck_oe; // [RQ6]
      alt_val[pos(PORT_C, 3)] = periph_i.spi_sck_out;
      alt_oe[pos(PORT_C, 4)] = periph_i.spi_mosi_oe; // [RQ6]
      alt_val[pos(PORT_C, 4)] = periph_i.spi_mosi_out;
      alt_oe[pos(PORT_C, 5)] = periph_i.spi_miso_oe; // [RQ6]
      alt_val[pos(PORT_C, 5)] = periph_i.spi_miso_out;
      per_d.spi_ss_in = ~alt_on[pos(PORT_C, 2)] | pin_i[pos(PORT_C, 2)];
      per_d.spi_sck_in = alt_on[pos(PORT_C, 3)] & pin_i[pos(PORT_C, 3)];
      per_d.spi_mosi_in = alt_on[pos(PORT_C, 4)] & pin_i[pos(PORT_C, 4)];
      per_d.spi_miso_in = alt_on[pos(PORT_C, 5)] & pin_i[pos(PORT_C, 5)];

      // Serial channel 1.
      alt_oe[pos(PORT_D, 3)] = 1'b1; // [RQ7]
      alt_val[pos(PORT_D, 3)] = periph_i.serial1_driver_enable;
      alt_oe[pos(PORT_D, 5)] = 1'b1; // [RQ7]
      alt_val[pos(PORT_D, 5)] = periph_i.serial1_transmit;
      per_d.serial1_receive = ~alt_on[pos(PORT_D, 4)]
                              | pin_i[pos(PORT_D, 4)]; // [RQ7]
      per_d.serial1_clear_to_send = ~alt_on[pos(PORT_D, 6)]
                                    | pin_i[pos(PORT_D, 6)]; // [RQ7]

      // Watchdog oscillator clock.
      alt_oe[pos(PORT_D, 7)] = 1'b1; // [RQ8]
      alt_val[pos(PORT_D, 7)] = periph_i.watchdog_osc_clock_out;

      // I2C drives only low; a high level releases the pin.
      alt_oe[pos(PORT_A, 6)] = ~periph_i.i2c_scl_out; // [RQ9]
      alt_oe[pos(PORT_A, 7)] = ~periph_i.i2c_sda_out; // [RQ9]
      per_d.i2c_scl_in = ~alt_on[pos(PORT_A, 6)] | pin_i[pos(PORT_A, 6)];
      per_d.i2c_sda_in = ~alt_on[pos(PORT_A, 7)] | pin_i[pos(PORT_A, 7)];

      // Analog inputs: driver off, digital path cut.
      for (int b = 0; b < PORT_W; b++) begin
         per_d.analog_select[b] = alt_on[pos(PORT_B, b)]; // [RQ15]
      end
      for (int b = 0; b < 4; b++) begin
         per_d.analog_select[8 + b] = alt_on[pos(PORT_H, b)]; // [RQ15]
      end

      // Final pin driver per bit.
      for (int p = 0; p < NUM_PORTS; p++) begin
         for (int b = 0; b < PORT_W; b++) begin
            if (alt_on[pos(p, b)]) begin
               out_d[pos(p, b)] = alt_val[pos(p, b)]; // [RQ2]
               oe_d[pos(p, b)] = alt_oe[pos(p, b)]; // [RQ2]
            end else begin
               out_d[pos(p, b)] = out_data_i[pos(p, b)];
               // Open-drain releases the pin for a one instead of driving it.
               oe_d[pos(p, b)] = (pin_direction_bits_q[p][b] == DIR_OUT)
                  & ~(odrain_q[p][b] & out_data_i[pos(p, b)]); // [RQ13]
            end
         end
      end
      out_d = out_d & IMPL; // [RQ12]
      oe_d = oe_d & IMPL; // [RQ12]

      // Analog pins do not feed the digital input path.
      in_d = pin_i & IMPL & ~(alt_on & ALT_EXISTS & 64'h0F00_0000_0000_FF00);
      // Pins handed to a peripheral raise no pin request.
      irq_en = IMPL & ~alt_on;
   end

   // Pins are driven from flip-flops so no glitch of the mux reaches them.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_q <= '0;
         oe_q <= '0;
         in_q <= '0;
         per_q <= '0;
      end else begin
         out_q <= out_d;
         oe_q <= oe_d;
         in_q <= in_d; // [RQ13]
         per_q <= per_d;
      end
   end

   // One detector per port, at the port's own width.
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port_edges
      pin_edge_detect #(
         .WIDTH(PORT_W)
      ) u_edges (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .level_i(in_d[p*PORT_W +: PORT_W]),
         .has_select_i(edge_select_avail_i[p*PORT_W +: PORT_W]),
         .rising_i(edge_rising_i[p*PORT_W +: PORT_W]),
         .enable_i(irq_en[p*PORT_W +: PORT_W]),
         .irq_o(irq_w[p*PORT_W +: PORT_W])
      );
   end

   // A second stage keeps the request registered; it costs one cycle.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_q <= '0;
      end else begin
         irq_q <= irq_w; // [RQ10] [RQ11]
      end
   end

   // Every output comes straight from a flip-flop.
   assign port_subreg_window_o = window_q;
   assign pin_o = out_q;
   assign pin_oe_o = oe_q;
   assign in_data_o = in_q;
   assign pin_irq_o = irq_q;
   assign periph_o = per_q;

endmodule : gpio_alt_function_mux
`default_nettype wire

// file: sim/gpio_alt_function_mux_asserts.sv
// Checker bound to the pin multiplexer top module.
`timescale 1ns/100ps
`default_nettype none
module gpio_alt_function_mux_asserts
   import pin_mux_pkg::*;
#(
   parameter package_t PKG = PKG_80
) (
   // Clock, reset and control port.
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [2:0] port_sel_i,
   input wire logic port_subreg_index_we_i,
   input wire logic port_subreg_window_we_i,
   input wire logic [7:0] wdata_i,
   input wire logic [7:0] port_subreg_window_o,
   // Pins and peripherals.
   input wire logic [63:0] out_data_i,
   input wire logic [63:0] edge_select_avail_i,
   input wire logic [63:0] edge_rising_i,
   input wire logic [63:0] pin_i,
   input wire logic [63:0] pin_o,
   input wire logic [63:0] pin_oe_o,
   input wire logic [63:0] in_data_o,
   input wire logic [63:0] pin_irq_o,
   input wire periph_out_t periph_i,
   input wire periph_in_t periph_o
);
   localparam logic [63:0] IMPL = (PKG == PKG_40) ? MASK_40 :
      (PKG == PKG_44) ? MASK_44 : (PKG == PKG_64) ? MASK_64 : MASK_80;
   logic [63:0] idx_q, dir_q, alt_q, od_q, gpio_m;
   logic [7:0] exp_q, cur_idx;
   logic [5:0] base;
   logic [2:0] wq_q;
   logic settled;
   assign base = {port_sel_i, 3'h0};
   assign cur_idx = idx_q[base +: 8];
   // Pins pass three edges after a write before outputs are judged.
   assign settled = (wq_q == 3'h0);
   // Pins without a function stay GPIO; only bonded pins are judged.
   assign gpio_m = (~alt_q | ~ALT_EXISTS) & IMPL;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx_q <= 64'h0;
         dir_q <= {8{DIR_RESET}};
         alt_q <= 64'h0;
         od_q <= 64'h0;
         exp_q <= 8'h00;
         wq_q <= 3'h7;
      end else begin
         wq_q <= {wq_q[1:0], port_subreg_window_we_i};
         if (port_subreg_index_we_i) begin
            idx_q[base +: 8] <= wdata_i;
         end
         if (port_subreg_window_we_i) begin
            exp_q <= (cur_idx > 8'h00 && cur_idx < 8'h04) ? wdata_i : 8'h00;
            case (cur_idx)
               SUBREG_DIR: dir_q[base +: 8] <= wdata_i;
               SUBREG_ALT: alt_q[base +: 8] <= wdata_i;
               SUBREG_ODRAIN: od_q[base +: 8] <= wdata_i;
               default: ;
            endcase
         end
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_quiet;
      !port_subreg_index_we_i && !port_subreg_window_we_i &&
      $stable(port_sel_i);
   endsequence
   a_window_readback: assert property (
      (port_subreg_window_we_i && IMPL[base +: 8] == 8'hFF) ##1 s_quiet [*2]
      |-> port_subreg_window_o == exp_q) else $error("readback wrong");
   a_irq_has_edge: assert property (
      (pin_irq_o & ~($past(in_data_o) ^ $past(in_data_o, 2))) == 64'h0)
      else $error("request without edge");
   a_irq_edge_sense: assert property (
      (pin_irq_o & $past(edge_select_avail_i, 2) &
      ($past(edge_rising_i, 2) ^ $past(in_data_o))) == 64'h0)
      else $error("request on wrong edge");
   a_gpio_input: assert property (
      settled |-> (pin_oe_o & gpio_m & dir_q) == 64'h0)
      else $error("input pin driven");
   a_gpio_drive: assert property (
      settled |-> (pin_oe_o & gpio_m & ~dir_q) ==
      (gpio_m & ~dir_q & ~(od_q & $past(out_data_i))) &&
      ((pin_o ^ $past(out_data_i)) & pin_oe_o & gpio_m) == 64'h0)
      else $error("output pin wrong");
   a_i2c_open_drain: assert property (
      settled && alt_q[7:6] == 2'b11 |-> pin_oe_o[7:6] ==
      ~$past({periph_i.i2c_sda_out, periph_i.i2c_scl_out}) &&
      (pin_o[7:6] & pin_oe_o[7:6]) == 2'b00) else $error("i2c drives high");
   a_timer_zero: assert property (
      settled && alt_q[1:0] == 2'b11 |-> pin_oe_o[1:0] == 2'b10 &&
      pin_o[1] == $past(periph_i.timer_zero_output) &&
      periph_o.timer_zero_input == $past(pin_i[0])) else $error("timer route");
   a_analog_route: assert property (
      settled |-> periph_o.analog_select[7:0] == alt_q[15:8] &&
      (in_data_o[15:8] & alt_q[15:8]) == 8'h00) else $error("analog route");
   c_irq_seen: cover property (pin_irq_o != 64'h0);
   c_i2c_low: cover property (settled && alt_q[7] && pin_oe_o[7]);
   c_readback: cover property (port_subreg_window_we_i ##3 settled);
endmodule : gpio_alt_function_mux_asserts
bind gpio_alt_function_mux gpio_alt_function_mux_asserts #(.PKG(PKG)) u_chk (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .port_sel_i(port_sel_i),
   .port_subreg_index_we_i(port_subreg_index_we_i),
   .port_subreg_window_we_i(port_subreg_window_we_i), .wdata_i(wdata_i),
   .port_subreg_window_o(port_subreg_window_o), .out_data_i(out_data_i),
   .edge_select_avail_i(edge_select_avail_i), .edge_rising_i(edge_rising_i),
   .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .in_data_o(in_data_o),
   .pin_irq_o(pin_irq_o), .periph_i(periph_i), .periph_o(periph_o));
`default_nettype wire

// file: sim/far_side_model.sv
// Far side: peripheral outputs and resolved pin levels.
`timescale 1ns/100ps
`default_nettype none
module far_side_model
   import pin_mux_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Pins and peripherals.
   input wire logic [63:0] pin_o_i,
   input wire logic [63:0] pin_oe_i,
   input wire logic [63:0] ext_i,
   input wire logic [1:0] i2c_pull_i,
   output logic [63:0] pin_lvl_o,
   output periph_out_t periph_o
);
   logic [18:0] cnt_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 19'h00000;
      end else begin
         cnt_q <= cnt_q + 19'h00001;
      end
   end
   // Each output other than the I2C lines and the MOSI enable toggles at its own rate, so a swapped route shows up.
   always_comb begin
      periph_o = cnt_q;
      periph_o.i2c_scl_out = i2c_pull_i[0];
      periph_o.i2c_sda_out = i2c_pull_i[1];
      // The SPI block acts as a slave here, so MOSI is always an input.
      periph_o.spi_mosi_oe = 1'b0;
   end
   // Released pins take the outside level; I2C pins see a pull-up there.
   assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule : far_side_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the pin multiplexer.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import pin_mux_pkg::*;
   logic clk_i, rst_n_i, iw, ww;
   logic [2:0] sel, seen;
   logic [1:0] pull;
   logic [7:0] wd, rb;
   logic [63:0] od_v, esa, er, ext, lvl, po, poe, ind, irq, ind40;
   logic [63:0] ind64, poe44, any_irq;
   logic [31:0] rows [6];
   periph_out_t pout;
   periph_in_t pside;
   int n_fail = 0;
   int samples_checked = 0;
   int cyc = 0;
   gpio_alt_function_mux u_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .port_sel_i(sel),
      .port_subreg_index_we_i(iw), .port_subreg_window_we_i(ww),
      .wdata_i(wd), .port_subreg_window_o(rb), .out_data_i(od_v),
      .edge_select_avail_i(esa), .edge_rising_i(er), .pin_i(lvl),
      .pin_o(po), .pin_oe_o(poe), .in_data_o(ind), .pin_irq_o(irq),
      .periph_i(pout), .periph_o(pside));
   gpio_alt_function_mux #(.PKG(PKG_40)) u_dut40 (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .port_sel_i(sel),
      .port_subreg_index_we_i(iw), .port_subreg_window_we_i(ww),
      .wdata_i(wd), .port_subreg_window_o(), .out_data_i(od_v),
      .edge_select_avail_i(esa), .edge_rising_i(er), .pin_i(lvl),
      .pin_o(), .pin_oe_o(), .in_data_o(ind40), .pin_irq_o(),
      .periph_i(pout), .periph_o());
   gpio_alt_function_mux #(.PKG(PKG_44)) u_dut44 (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .port_sel_i(sel),
      .port_subreg_index_we_i(iw), .port_subreg_window_we_i(ww),
      .wdata_i(wd), .port_subreg_window_o(), .out_data_i(od_v),
      .edge_select_avail_i(esa), .edge_rising_i(er), .pin_i(lvl),
      .pin_o(), .pin_oe_o(poe44), .in_data_o(), .pin_irq_o(),
      .periph_i(pout), .periph_o());
   gpio_alt_function_mux #(.PKG(PKG_64)) u_dut64 (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .port_sel_i(sel),
      .port_subreg_index_we_i(iw), .port_subreg_window_we_i(ww),
      .wdata_i(wd), .port_subreg_window_o(), .out_data_i(od_v),
      .edge_select_avail_i(esa), .edge_rising_i(er), .pin_i(lvl),
      .pin_o(), .pin_oe_o(), .in_data_o(ind64), .pin_irq_o(),
      .periph_i(pout), .periph_o());
   far_side_model u_far (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .pin_o_i(po), .pin_oe_i(poe),
      .ext_i(ext), .i2c_pull_i(pull), .pin_lvl_o(lvl), .periph_o(pout));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         wrap_up();
      end
   end
   task automatic check(input string nm, input logic [63:0] exp, got);
      samples_checked++;
      if (exp !== got) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic iwr(input logic [2:0] p, input logic [7:0] i);
      @(posedge clk_i);
      #1;
      sel = p;
      iw = 1'b1;
      wd = i;
      @(posedge clk_i);
      #1;
      iw = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask : iwr
   task automatic wwr(input logic [7:0] d);
      @(posedge clk_i);
      #1;
      ww = 1'b1;
      wd = d;
      @(posedge clk_i);
      #1;
      ww = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
   endtask : wwr
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      rst_n_i = 1'b0;
      {iw, ww, sel, wd, pull} = '0;
      od_v = 64'h0000_003C_0000_0000;
      esa = 64'h0000_0300_0000_0000;
      er = 64'h0000_0100_0000_0000;
      ext = 64'hFFFF_FFFF_EFEF_FFEF;
      rows = '{32'h0001_5A5A, 32'h0202_3C3C, 32'h0303_8181,
               32'h0404_FF00, 32'h0500_1200, 32'h0601_0F0F};
      repeat (16) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      iwr(3'h0, SUBREG_DIR);
      check("dir reset", 64'(rb), 64'(DIR_RESET));
      check("pkg40 pins", ind40, MASK_40 & ext);
      check("pkg64 pins", ind64, MASK_64 & ext);
      iwr(3'h0, SUBREG_ALT);
      check("alt reset", 64'(rb), 64'(ALT_RESET));
      $display("test reset done");
      foreach (rows[k]) begin
         iwr(rows[k][26:24], rows[k][23:16]);
         wwr(rows[k][15:8]);
         check("window", 64'(rb), 64'(rows[k][7:0]));
      end
      $display("test table done");
      // Every port gets its select set, including ports with no function.
      for (int p = 0; p < NUM_PORTS; p++) begin
         iwr(p[2:0], SUBREG_ALT);
         wwr(8'hFF);
      end
      iwr(3'h4, SUBREG_DIR);
      wwr(8'h00);
      pull = 2'b01;
      repeat (3) @(posedge clk_i);
      #1;
      check("gpio e", 64'(po[39:32]), 64'(od_v[39:32]));
      check("gpio e oe", 64'(poe[39:32]), 64'h00FF);
      check("dir taken", 64'(poe[5:0]), 64'h26);
      check("i2c", 64'({poe[7:6], po[7]}), 64'h4);
      check("port d oe", 64'(poe[31:27]), 64'h15);
      check("timer three", 64'({poe[25:24], poe44[25:24]}), 64'h8);
      check("inputs", 64'({pside.serial0_receive, pside.serial1_receive,
         pside.spi_mosi_in, pside.timer_one_input, pside.timer_two_input,
         pside.timer_three_input}), 64'h07);
      check("analog", 64'({pside.analog_select, ind[15:8]}), 64'hFFF00);
      $display("test routing done");
      for (int k = 0; k < 2; k++) begin
         seen = 3'h0;
         ext[42:40] = k ? 3'h7 : 3'h0;
         repeat (5) begin
            @(posedge clk_i);
            #1;
            seen = seen | irq[42:40];
         end
         check("irq", 64'(seen), k ? 64'h5 : 64'h6);
      end
      $display("test edges done");
      // Reset in mid-run with many pins high: no request may follow.
      rst_n_i = 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      any_irq = 64'h0;
      repeat (5) begin
         @(posedge clk_i);
         #1;
         any_irq = any_irq | irq;
      end
      check("irq after reset", any_irq, 64'h0);
      check("oe after reset", poe, 64'h0);
      $display("test mid reset done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
